// file: design/atcr_top.sv
// aux 16-bit timer with capture, auto-reload and baud generation, AHB-Lite slave
// assumes synchronous pins, one clock, single word transfers, OKAY answers only
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "atcr_defs.svh"
module atcr_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        aux_count_pin,
    input  wire logic        aux_trigger_pin,
    input  wire logic        timer1_overflow,
    output logic             rx_baud_tick,
    output logic             tx_baud_tick,
    output logic             aux_irq_request,
    output logic             aux_irq_high_priority
);

    // bus side
    atcr_pkg::atcr_ahb_req_type   req;
    atcr_pkg::atcr_bus_state_type bus_state_q;
    atcr_pkg::atcr_bus_state_type bus_state_d;
    logic                         addr_phase;
    logic                         wr_pending_q;
    logic [7:0]                   idx_q;
    logic [7:0]                   wr_byte;
    logic [7:0]                   rd_byte;
    logic [31:0]                  hrdata_q;

    // register state
    atcr_pkg::atcr_ctrl_type      ctrl_q;
    logic [7:0]                   ie_q;
    logic [7:0]                   ip_q;
    logic [7:0]                   mode_q;
    logic [7:0]                   cksel_q;
    logic [7:0]                   rcap_bytes [2];
    logic [15:0]                  rcap_value;
    logic [15:0]                  cnt_q;
    logic [15:0]                  cnt_d;

    // decoded modes and one-cycle events
    logic                         ctrl_wr;
    logic                         cnt_wr;
    logic                         baud_mode;
    logic                         capture_mode;
    logic                         reload_mode;
    logic                         down_mode;
    logic                         count_up;
    logic                         trig_fall;
    logic                         count_fall;
    logic                         tick;
    logic                         trig_evt;
    logic                         cap_evt;
    logic                         reload_evt;
    logic                         at_limit;
    logic                         ovf_evt;
    logic                         tf_set;
    logic                         exf_set;
    logic                         irq_q;
    logic                         rx_tick_q;
    logic                         tx_tick_q;

    // true when the write now in its data phase targets register idx
    function automatic logic wr_hit(
        input logic       pending,
        input logic [7:0] at,
        input logic [7:0] idx
    );
        return pending && (at == idx);
    endfunction

    assign req        = '{sel: hsel, trans: htrans, write: hwrite};
    // only whole-word transfers are taken; narrower ones are ignored
    assign addr_phase = req.sel && req.trans[1] && hready && (hsize == 3'h2);
    assign wr_byte    = hwdata[7:0];
    assign hresp      = 1'b0;
    assign hreadyout  = (bus_state_q == atcr_pkg::ATCR_BUS_IDLE);
    assign hrdata     = hrdata_q;
    assign ctrl_wr    = wr_hit(wr_pending_q, idx_q, `ATCR_IDX_CTRL);
    assign cnt_wr     = wr_hit(wr_pending_q, idx_q, `ATCR_IDX_CNTL) || wr_hit(wr_pending_q, idx_q, `ATCR_IDX_CNTH);

    // reads take one wait state so a write landing at the read's address edge is seen
    always_comb
    begin
        bus_state_d = bus_state_q;
        case (bus_state_q)
            atcr_pkg::ATCR_BUS_IDLE:
                if (addr_phase && !req.write)
                    bus_state_d = atcr_pkg::ATCR_BUS_RD;
            atcr_pkg::ATCR_BUS_RD:
                bus_state_d = atcr_pkg::ATCR_BUS_IDLE;
            default:
                bus_state_d = atcr_pkg::ATCR_BUS_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bus_state_q <= atcr_pkg::ATCR_BUS_IDLE;
        else
            bus_state_q <= bus_state_d;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pending_q <= 1'b0;
            idx_q        <= 8'h00;
        end
        else if (hready)
        begin
            wr_pending_q <= addr_phase && req.write;
            if (addr_phase)
                idx_q <= haddr[9:2];
        end
    end

    // read mux over the register index
    always_comb
    begin
        rd_byte = 8'h00;
        case (idx_q)
            `ATCR_IDX_IE:    rd_byte = ie_q;
            `ATCR_IDX_IP:
            begin
                rd_byte                  = ip_q;
                rd_byte[`ATCR_IP_UNUSED] = 1'b1;
            end
            `ATCR_IDX_CTRL:  rd_byte = ctrl_q;
            `ATCR_IDX_MODE:  rd_byte = mode_q;
            `ATCR_IDX_RCL:   rd_byte = rcap_bytes[0];
            `ATCR_IDX_RCH:   rd_byte = rcap_bytes[1];
            `ATCR_IDX_CNTL:  rd_byte = cnt_q[7:0];
            `ATCR_IDX_CNTH:  rd_byte = cnt_q[15:8];
            `ATCR_IDX_CKSEL: rd_byte = cksel_q;
            default:         rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h0000_0000;
        else if (bus_state_q == atcr_pkg::ATCR_BUS_RD)
            hrdata_q <= {24'h00_0000, rd_byte};
    end

    // a hardware set in the same cycle as a software write wins, so no event is lost
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_q <= `ATCR_RST_BYTE;
        else
        begin
            if (ctrl_wr)
                ctrl_q <= wr_byte; // see [RULE3]
            if (tf_set)
                ctrl_q.tf <= 1'b1; // see [RULE1] see [RULE2]
            if (exf_set)
                ctrl_q.exf <= 1'b1; // see [RULE4] see [RULE5]
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ie_q <= `ATCR_RST_BYTE;
        else if (wr_hit(wr_pending_q, idx_q, `ATCR_IDX_IE))
            ie_q <= wr_byte;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ip_q <= `ATCR_RST_BYTE;
        else if (wr_hit(wr_pending_q, idx_q, `ATCR_IDX_IP))
            ip_q <= wr_byte;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mode_q <= `ATCR_RST_BYTE;
        else if (wr_hit(wr_pending_q, idx_q, `ATCR_IDX_MODE))
            mode_q <= wr_byte;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cksel_q <= `ATCR_RST_BYTE;
        else if (wr_hit(wr_pending_q, idx_q, `ATCR_IDX_CKSEL))
            cksel_q <= wr_byte;
    end

    // with down-count on, the trigger pin sets direction and no longer reloads
    assign baud_mode    = ctrl_q.rclk | ctrl_q.tclk;                // see [RULE6] see [RULE7]
    assign capture_mode = ctrl_q.cprl & ~baud_mode;                 // see [RULE12]
    assign reload_mode  = ~capture_mode;                            // see [RULE13]
    assign down_mode    = reload_mode & ~baud_mode & mode_q[`ATCR_MODE_DOWN_COUNT_ENABLE];
    assign count_up     = ~down_mode | aux_trigger_pin;             // see [RULE18]
    assign trig_evt     = trig_fall & ctrl_q.exen & ~baud_mode;     // see [RULE8]
    assign cap_evt      = trig_evt & capture_mode;                  // see [RULE14]
    assign reload_evt   = trig_evt & reload_mode & ~down_mode;      // see [RULE13]
    assign rcap_value   = {rcap_bytes[1], rcap_bytes[0]};           // see [RULE19]
    assign at_limit     = count_up ? (cnt_q == 16'hffff) : (cnt_q == rcap_value); // see [RULE20]
    assign ovf_evt      = tick & at_limit;
    assign tf_set       = ovf_evt & ~baud_mode;
    assign exf_set      = trig_evt | (ovf_evt & down_mode);

    atcr_fall_detect u_trig_fall (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (aux_trigger_pin),
        .fall    (trig_fall)
    );

    atcr_fall_detect u_count_fall (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (aux_count_pin),
        .fall    (count_fall)
    );

    atcr_prescaler u_prescaler (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .run          (ctrl_q.tr),
        .baud         (baud_mode),
        .counter_sel  (ctrl_q.ct),
        .prescale_sel (cksel_q[`ATCR_CKSEL_PRE]),
        .pin_fall     (count_fall),
        .tick         (tick)
    );

    // a software byte write overrides the hardware update of the count byte it writes; the other byte still updates
    always_comb
    begin
        cnt_d = cnt_q;
        if (cap_evt && mode_q[`ATCR_MODE_CLR])
            cnt_d = `ATCR_RST_CNT; // see [RULE15]
        else if (ovf_evt)
        begin
            if (!count_up)
                cnt_d = 16'hffff;
            else if (reload_mode)
                cnt_d = rcap_value; // see [RULE12] see [RULE13]
            else
                cnt_d = 16'h0000;
        end
        else if (tick)
            cnt_d = count_up ? cnt_q + 16'd1 : cnt_q - 16'd1;
        else if (reload_evt)
            cnt_d = rcap_value;
        if (wr_hit(wr_pending_q, idx_q, `ATCR_IDX_CNTL))
            cnt_d[7:0] = wr_byte;
        if (wr_hit(wr_pending_q, idx_q, `ATCR_IDX_CNTH))
            cnt_d[15:8] = wr_byte;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= `ATCR_RST_CNT;
        else
            cnt_q <= cnt_d; // see [RULE9]
    end

    // a capture wins over a software write to the same byte
    for (genvar g = 0; g < 2; g++)
    begin : g_rcap
        logic [7:0] byte_q;
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                byte_q <= `ATCR_RST_BYTE;
            else if (cap_evt)
                byte_q <= cnt_q[8*g +: 8]; // see [RULE14] see [RULE19]
            else if (wr_hit(wr_pending_q, idx_q, 8'(`ATCR_IDX_RCL + g)))
                byte_q <= wr_byte;
        end
        assign rcap_bytes[g] = byte_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_q <= 1'b0;
        else
            irq_q <= ie_q[`ATCR_IE_GLOBAL] & ie_q[`ATCR_IE_AUX] & (ctrl_q.tf | ctrl_q.exf); // see [RULE16]
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_tick_q <= 1'b0;
            tx_tick_q <= 1'b0;
        end
        else
        begin
            rx_tick_q <= ctrl_q.rclk ? ovf_evt : timer1_overflow; // see [RULE6]
            tx_tick_q <= ctrl_q.tclk ? ovf_evt : timer1_overflow; // see [RULE7]
        end
    end

    assign aux_irq_request       = irq_q;
    assign aux_irq_high_priority = ip_q[`ATCR_IP_AUX]; // see [RULE17]
    assign rx_baud_tick          = rx_tick_q;
    assign tx_baud_tick          = tx_tick_q;

    // checks on the flags, the count and the request
    sequence s_capture;
        cap_evt;
    endsequence

    property p_tf_ovf_set;
        @(posedge hclk) disable iff (!hresetn) (ovf_evt && !baud_mode) |=> ctrl_q.tf;
    endproperty
    a_tf_ovf_set: assert property (p_tf_ovf_set) else $error("overflow did not set the flag"); // see [RULE1]
    property p_tf_baud_quiet;
        @(posedge hclk) disable iff (!hresetn) (baud_mode && !ctrl_q.tf && !ctrl_wr) |=> !ctrl_q.tf;
    endproperty
    a_tf_baud_quiet: assert property (p_tf_baud_quiet) else $error("flag set in baud mode"); // see [RULE2]
    property p_tf_sticky;
        @(posedge hclk) disable iff (!hresetn) (ctrl_q.tf && !ctrl_wr) |=> ctrl_q.tf;
    endproperty
    a_tf_sticky: assert property (p_tf_sticky) else $error("flag cleared by hardware"); // see [RULE3]
    property p_run_hold;
        @(posedge hclk) disable iff (!hresetn) (!ctrl_q.tr && !cnt_wr && !trig_evt) |=> $stable(cnt_q);
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("stopped count moved"); // see [RULE9]
    property p_baud_rate;
        @(posedge hclk) disable iff (!hresetn) (baud_mode && tick) |=> (!tick || !baud_mode);
    endproperty
    a_baud_rate: assert property (p_baud_rate) else $error("baud ticks too close"); // see [RULE11]
    property p_capture_copy;
        @(posedge hclk) disable iff (!hresetn) s_capture |=> (rcap_value == $past(cnt_q));
    endproperty
    a_capture_copy: assert property (p_capture_copy) else $error("capture lost the count"); // see [RULE14]
    property p_capture_clear;
        @(posedge hclk) disable iff (!hresetn) (s_capture ##0 (mode_q[`ATCR_MODE_CLR] && !cnt_wr)) |=> (cnt_q == 16'h0000);
    endproperty
    a_capture_clear: assert property (p_capture_clear) else $error("count not cleared"); // see [RULE15]
    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn) (!ie_q[`ATCR_IE_GLOBAL] || !ie_q[`ATCR_IE_AUX]) |=> !aux_irq_request;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("masked request raised"); // see [RULE16]
endmodule

// file: design/atcr_defs.svh
// constants of the aux timer with capture and reload: offsets, fields, resets, counts
// assumes a 10 MHz hclk and a word-wide AHB-Lite register port
// Operation
// [RULE1] overflow flag set on 16-bit wrap, or on down-count match with capture value
// [RULE2] overflow flag set by hardware only while both baud selects are zero
// [RULE3] hardware never clears overflow flag; software writes may set or clear it
// [RULE4] external flag set by trigger fall or overflow, per mode; software clears it
// [RULE5] external flag set by software or trigger fall requests the aux interrupt
// [RULE6] receive baud select picks timer 1 or aux overflow; forces baud mode
// [RULE7] transmit baud select picks timer 1 or aux overflow; forces baud mode
// [RULE8] trigger fall captures or reloads when enabled and not in baud mode
// [RULE9] run control gates counting; clearing it holds the count bytes
// [RULE10] timer mode counts prescaled clock; counter mode counts count-pin falls
// [RULE11] baud generator mode advances once every two clocks
// [RULE12] any baud select forces auto-reload after each overflow
// [RULE13] reload mode reloads on overflow, and on enabled trigger fall
// [RULE14] capture mode copies count into capture registers on enabled trigger fall
// [RULE15] capture auto-clear zeroes the counter right after the capture
// [RULE16] interrupt request needs local enable and global enable
// [RULE17] priority bit one gives the high level, zero the low level
// [RULE18] down-count enable with trigger pin level sets direction in reload mode
// [RULE19] capture registers take count bytes, or supply the 16-bit reload value
// [RULE20] counter is 16 bits; counting up it overflows from all ones to zero
`ifndef ATCR_DEFS_SVH
`define ATCR_DEFS_SVH
// register indexes; the byte address is four times the index
`define ATCR_IDX_IE      8'ha8
`define ATCR_IDX_IP      8'hb8
`define ATCR_IDX_CTRL    8'hc8
`define ATCR_IDX_MODE    8'hc9
`define ATCR_IDX_RCL     8'hca
`define ATCR_IDX_RCH     8'hcb
`define ATCR_IDX_CNTL    8'hcc
`define ATCR_IDX_CNTH    8'hcd
`define ATCR_IDX_CKSEL   8'hce
// field positions
`define ATCR_IE_GLOBAL   7
`define ATCR_IE_AUX      5
`define ATCR_IP_UNUSED   7
`define ATCR_IP_AUX      5
`define ATCR_MODE_CLR    3
`define ATCR_MODE_DOWN_COUNT_ENABLE   0
`define ATCR_CKSEL_PRE   0
// reset values
`define ATCR_RST_BYTE    8'h00
`define ATCR_RST_CNT     16'h0000
// timing: hclk period in ns, then divider counts in hclk cycles
`define ATCR_CLK_NS      100
`define ATCR_BAUD_DIV    4'd2
`define ATCR_FAST_DIV    4'd4
`define ATCR_SLOW_DIV    4'd12
`endif

// file: design/atcr_pkg.sv
// types of the aux timer with capture and reload
// assumes nothing beyond the constants header
package atcr_pkg;
    // control byte, most significant field first
    typedef struct packed {
        logic tf;
        logic exf;
        logic rclk;
        logic tclk;
        logic exen;
        logic tr;
        logic ct;
        logic cprl;
    } atcr_ctrl_type;

    typedef struct packed {
        logic       sel;
        logic [1:0] trans;
        logic       write;
    } atcr_ahb_req_type;

    typedef enum logic [0:0] {
        ATCR_BUS_IDLE = 1'b0,
        ATCR_BUS_RD   = 1'b1
    } atcr_bus_state_type;
endpackage

// file: design/atcr_fall_detect.sv
// falling-edge detector for a pin sampled on hclk
// assumes the pin is already synchronous to hclk
`timescale 1ns/1ps
module atcr_fall_detect (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    output logic      fall
);
    logic prev_q;

    // starts high so a pin low at release is taken as a falling edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prev_q <= 1'b1;
        else
            prev_q <= pin;
    end

    assign fall = prev_q & ~pin;
endmodule

// file: design/atcr_prescaler.sv
// tick generator for the aux counter: baud, timer or external count source
// assumes the count-pin fall pulse comes from an edge detector on hclk
`timescale 1ns/1ps
`include "atcr_defs.svh"
module atcr_prescaler (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic run,
    input  wire logic baud,
    input  wire logic counter_sel,
    input  wire logic prescale_sel,
    input  wire logic pin_fall,
    output logic      tick
);
    logic [3:0] div_q;
    logic [3:0] limit;
    logic       use_pin;

    assign limit   = baud ? `ATCR_BAUD_DIV : (prescale_sel ? `ATCR_FAST_DIV : `ATCR_SLOW_DIV);
    assign use_pin = counter_sel & ~baud;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_q <= 4'h0;
        else if (!run || use_pin || div_q == limit - 4'd1) // see [RULE9]
            div_q <= 4'h0;
        else
            div_q <= div_q + 4'd1;
    end

    // see [RULE10] see [RULE11]
    assign tick = run & (use_pin ? pin_fall : (div_q == limit - 4'd1));
endmodule

// file: tb/atcr_pins.sv
// pin model: the trigger pin idles high like a pulled-up port line
// assumes fire changes just after a rising hclk edge
`timescale 1ns/1ps
module atcr_pins (
    input  wire logic hclk,
    input  wire logic fire,
    output logic      trig
);
    always_ff @(posedge hclk)
        trig <= !fire;
endmodule

// file: tb/testbench.sv
// bench: AHB-Lite register tasks, overflow, clear and capture runs
// assumes one slave, so hready follows hreadyout
`timescale 1ns/1ps
`include "atcr_defs.svh"
module testbench;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
    logic        hready, hreadyout, hresp, aux_trigger_pin, aux_irq_request, aux_irq_high_priority;
    logic        rx_baud_tick, tx_baud_tick;
    logic        aux_count_pin = 1'b1, timer1_overflow = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v, w;
    int          mismatches = 0, total_checks = 0;
    always #50 hclk = ~hclk;
    assign hready = hreadyout;
    atcr_top u_dut (.*);
    atcr_pins u_pins (.hclk, .fire, .trig(aux_trigger_pin));
    task give_verdict(input int hang);
        mismatches += hang;
        $display("%0d checks %0d errors", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string s, input [31:0] seen, input [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask
    // byte address is four times the register index
    task acc(input wr, input [7:0] i, input [31:0] d);
        int n;
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 22'h0, i, 2'h0};
        for (int p = 0; p < 2; p++)
        begin
            n = 0;
            @(posedge hclk);
            while (hreadyout !== 1'b1 && n < 40)
            begin
                n++;
                @(posedge hclk);
            end
            if (n >= 40)
                give_verdict(1);
            // the data phase starts at this edge, so htrans goes idle and hwdata is driven once
            if (p == 0)
                {htrans, hwdata} <= {2'h0, d};
        end
        v = hrdata;
    endtask
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        acc(1'b1, `ATCR_IDX_RCH, 32'h12);
        acc(1'b1, `ATCR_IDX_CNTH, 32'hff);
        acc(1'b1, `ATCR_IDX_CTRL, 32'h04);
        repeat (3200) @(posedge hclk);
        acc(1'b0, `ATCR_IDX_CTRL, 32'h0);
        chk("ovf", v & 32'h80, 32'h80);
        acc(1'b0, `ATCR_IDX_CNTH, 32'h0);
        chk("cnth", v, 32'h12);
        acc(1'b1, `ATCR_IDX_CTRL, 32'h0);
        acc(1'b0, `ATCR_IDX_CTRL, 32'h0);
        chk("ovf", v & 32'h80, 32'h0);
        acc(1'b0, `ATCR_IDX_CNTL, 32'h0);
        w = v;
        acc(1'b1, `ATCR_IDX_IE, 32'ha0);
        acc(1'b1, `ATCR_IDX_IP, 32'h20);
        acc(1'b1, `ATCR_IDX_CTRL, 32'h09);
        fire <= 1'b1;
        repeat (4) @(posedge hclk);
        chk("irq", {30'h0, aux_irq_request, aux_irq_high_priority}, 32'h3);
        acc(1'b0, `ATCR_IDX_CTRL, 32'h0);
        chk("exf", v & 32'h40, 32'h40);
        acc(1'b0, `ATCR_IDX_RCL, 32'h0);
        chk("cap", v, w);
        // second capture with auto-clear on
        acc(1'b1, `ATCR_IDX_MODE, 32'h08);
        fire <= 1'b0;
        repeat (2) @(posedge hclk);
        fire <= 1'b1;
        repeat (3) @(posedge hclk);
        acc(1'b0, `ATCR_IDX_CNTH, 32'h0);
        chk("clr", v, 32'h0);
        acc(1'b0, `ATCR_IDX_RCH, 32'h0);
        chk("caph", v, 32'h12);
        timer1_overflow <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("baud", {30'h0, rx_baud_tick, tx_baud_tick}, 32'h3);
        give_verdict(0);
    end
endmodule
